// *** hdl/card_host_pkg.sv ***
package card_host_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] MODE_OFS   = 8'h04;
  localparam logic [7:0] DTO_OFS    = 8'h08;
  localparam logic [7:0] SLOT_OFS   = 8'h0C;
  localparam logic [7:0] ARG_OFS    = 8'h10;
  localparam logic [7:0] CMD_OFS    = 8'h14;
  localparam logic [7:0] BLK_OFS    = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h40;
  // ==========================================
  // reset values
  localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  // ==========================================
  // field positions
  localparam int RD_HOLD_BIT   = 11;
  localparam int WR_HOLD_BIT   = 12;
  localparam int DMA_BYTE_BIT  = 13;
  localparam int PAD_SEL_BIT   = 14;
  localparam int DMA_MODE_BIT  = 15;
  localparam int BLK_LEN_LSB   = 16;
  localparam int DTO_CYC_LSB   = 0;
  localparam int DTO_MUL_LSB   = 4;
  localparam int SLOT_LSB      = 0;
  localparam int BUS_BIT       = 7;
  localparam int IDX_LSB       = 0;
  localparam int RSP_LSB       = 6;
  localparam int SPC_LSB       = 8;
  localparam int OD_BIT        = 11;
  localparam int LAT_BIT       = 12;
  localparam int TRC_LSB       = 16;
  localparam int DIR_BIT       = 18;
  localparam int KIND_LSB      = 19;
  localparam int SDIO_SR_LSB   = 24;
  localparam int DONE_BIT      = 0;
  localparam int RTO_BIT       = 20;
  localparam int DATA_TIMEOUT_ERROR_BIT      = 22;
  localparam int OVR_BIT       = 30;
  localparam int UNR_BIT       = 31;
  // ==========================================
  // codes
  localparam logic [2:0] SPC_NONE   = 3'h0;
  localparam logic [2:0] SPC_INIT   = 3'h1;
  localparam logic [2:0] SPC_SYNC   = 3'h2;
  localparam logic [2:0] SPC_INT    = 3'h4;
  localparam logic [2:0] SPC_INTRSP = 3'h5;
  localparam logic [1:0] RSP_NONE   = 2'h0;
  localparam logic [2:0] KIND_SDIO_BYTE = 3'h4;
  localparam logic [7:0] PAD_LOW    = 8'h00;
  localparam logic [7:0] PAD_HIGH   = 8'hFF;
  // ==========================================
  // timing, in card clock cycles
  localparam logic [6:0] INIT_CYCLES = 7'h4A;
  localparam logic [6:0] LAT_SHORT   = 7'h05;
  localparam logic [6:0] LAT_LONG    = 7'h40;
  // ==========================================
  // command sequencer states
  typedef enum logic [4:0] {
    IDLE = 5'b00001,
    INIT = 5'b00010,
    SYNC = 5'b00100,
    SEND = 5'b01000,
    RESP = 5'b10000
  } seq_state_type;
endpackage

// *** hdl/card_host_interface.sv ***
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns
// Function
// (R1) read flow hold stops card clock in reads while fifo full
// (R2) write flow hold stops card clock in writes while fifo full
// (R3) dma byte mode clear moves words, set moves bytes
// (R4) write padding byte is 0x00 or 0xFF by pad select bit
// (R5) dma mode clears underrun and overrun after dma completion; off disables dma
// (R6) software keeps block length bits 16 and 17 zero without byte mode
// (R7) block length is one store seen through mode and block registers
// (R8) sdio byte transfers ignore block length
// (R9) data timeout is cycle count times multiplier chosen by code
// (R10) elapsed data timeout sets data timeout error flag
// (R11) slot select 00 slot a, 01 slot b, others reserved
// (R12) bus width bit picks one or four data lines
// (R13) command writes ignored while command done flag is zero
// (R14) after interrupt command only interrupt response write accepted
// (R15) command index sent; response kind none, 48 or 136 bits
// (R16) special code 001 issues 74 card clock init cycles
// (R17) special code 010 waits end of data block before sending
// (R18) codes 100 and 101 interrupt command and response; 000 none
// (R19) command line push pull or open drain by select bit
// (R20) response latency at most 5 or 64 cycles by select bit
// (R21) sdio code marks ordinary, suspend or resume command
// (R22) transfer control, direction and kind passed with command
// (R23) block register: count low half, shared length high half
// (R24) command done flag set after send, cleared by command write
module card_host_interface (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        card_clk_i,
  input  wire logic        fifo_full_i,
  input  wire logic        xfer_active_i,
  input  wire logic        data_wait_i,
  input  wire logic        block_end_i,
  input  wire logic        cmd_sent_i,
  input  wire logic        resp_start_i,
  input  wire logic        dma_done_i,
  input  wire logic        underrun_i,
  input  wire logic        overrun_i,
  output logic             card_clk_halt_o,
  output logic             dma_en_o,
  output logic             dma_byte_mode_o,
  output logic      [7:0]  pad_byte_o,
  output logic      [15:0] block_length_o,
  output logic      [15:0] block_or_byte_count_o,
  output logic      [1:0]  card_slot_select_o,
  output logic             card_bus_width_o,
  output logic             cmd_start_o,
  output logic             init_seq_o,
  output logic      [5:0]  command_index_o,
  output logic      [31:0] command_argument_value_o,
  output logic      [1:0]  response_kind_o,
  output logic             open_drain_select_o,
  output logic      [1:0]  transfer_control_o,
  output logic             transfer_direction_o,
  output logic      [2:0]  transfer_kind_o,
  output logic      [1:0]  sdio_suspend_resume_code_o,
  output logic             command_done_flag_o,
  output logic             data_timeout_error_o
);

  typedef struct packed {
    card_host_pkg::seq_state_type state;
    logic [15:0] mode;
    logic [15:0] block_length;
    logic [6:0]  dto;
    logic [1:0]  slot;
    logic        bus;
    logic [31:0] arg;
    logic [31:0] cmd;
    logic [15:0] count;
    logic        done;
    logic        int_pend;
    logic        dto_err;
    logic        resp_to;
    logic        under;
    logic        over;
    logic        clk_s1;
    logic        clk_s2;
    logic        clk_s3;
    logic [6:0]  edges;
    logic [23:0] to_cnt;
    logic [31:0] rdata;
    logic        start;
    logic        halt;
    logic [7:0]  pad;
    logic [15:0] len_out;
  } state_type;

  state_type s;
  state_type next_s;

  // ==========================================
  // helpers
  function automatic logic [23:0] dto_limit(input logic [6:0] f); // (R9)
    logic [23:0] m;
    m = 24'h00_0001;
    case (f[6:4])
      3'h0: m = 24'h00_0001;
      3'h1: m = 24'h00_0010;
      3'h2: m = 24'h00_0080;
      3'h3: m = 24'h00_0100;
      3'h4: m = 24'h00_0400;
      3'h5: m = 24'h00_1000;
      3'h6: m = 24'h01_0000;
      default: m = 24'h10_0000;
    endcase
    dto_limit = m * {20'h0_0000, f[3:0]};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic        card_edge;
  logic        cmd_ok;
  logic [2:0]  new_spc;
  logic [6:0]  lat_max;

  // ==========================================
  // next state
  always_comb begin
    next_s = s;
    card_edge = s.clk_s2 & ~s.clk_s3;
    new_spc = reg_wdata_i[card_host_pkg::SPC_LSB +: 3];
    lat_max = s.cmd[card_host_pkg::LAT_BIT] ? card_host_pkg::LAT_LONG
                                            : card_host_pkg::LAT_SHORT; // (R20)
    cmd_ok = reg_wr_i && hit(reg_addr_i, card_host_pkg::CMD_OFS) && s.done // (R13)
             && (!s.int_pend || new_spc == card_host_pkg::SPC_INTRSP); // (R14)
    next_s.clk_s1 = card_clk_i;
    next_s.clk_s2 = s.clk_s1;
    next_s.clk_s3 = s.clk_s2;
    next_s.start = 1'b0;
    next_s.rdata = card_host_pkg::ZERO_RESET;

    if (reg_wr_i) begin
      if (hit(reg_addr_i, card_host_pkg::MODE_OFS)) begin
        next_s.mode = reg_wdata_i[15:0];
        next_s.block_length = reg_wdata_i[31:16]; // (R7)
      end
      if (hit(reg_addr_i, card_host_pkg::DTO_OFS)) begin
        next_s.dto = reg_wdata_i[6:0];
      end
      if (hit(reg_addr_i, card_host_pkg::SLOT_OFS)) begin
        next_s.slot = reg_wdata_i[card_host_pkg::SLOT_LSB +: 2]; // (R11)
        next_s.bus = reg_wdata_i[card_host_pkg::BUS_BIT]; // (R12)
      end
      if (hit(reg_addr_i, card_host_pkg::ARG_OFS)) begin
        next_s.arg = reg_wdata_i;
      end
      if (hit(reg_addr_i, card_host_pkg::BLK_OFS)) begin
        next_s.count = reg_wdata_i[15:0]; // (R23)
        next_s.block_length = reg_wdata_i[31:16]; // (R7)
      end
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        card_host_pkg::MODE_OFS: next_s.rdata = {s.block_length, s.mode};
        card_host_pkg::DTO_OFS:  next_s.rdata = {25'h000_0000, s.dto};
        card_host_pkg::SLOT_OFS: next_s.rdata = {24'h00_0000, s.bus, 5'h00, s.slot};
        card_host_pkg::ARG_OFS:  next_s.rdata = s.arg;
        card_host_pkg::BLK_OFS:  next_s.rdata = {s.block_length, s.count}; // (R23)
        card_host_pkg::STATUS_OFS: begin
          next_s.rdata[card_host_pkg::DONE_BIT] = s.done;
          next_s.rdata[card_host_pkg::RTO_BIT]  = s.resp_to;
          next_s.rdata[card_host_pkg::DATA_TIMEOUT_ERROR_BIT] = s.dto_err;
          next_s.rdata[card_host_pkg::OVR_BIT]  = s.over;
          next_s.rdata[card_host_pkg::UNR_BIT]  = s.under;
        end
        default: next_s.rdata = card_host_pkg::ZERO_RESET;
      endcase
    end

    // reading status clears the timeout flags; a new timeout wins
    if (reg_rd_i && hit(reg_addr_i, card_host_pkg::STATUS_OFS)) begin
      next_s.dto_err = 1'b0;
      next_s.resp_to = 1'b0;
    end

    // data timeout restarts whenever no block is awaited
    if (!data_wait_i) begin
      next_s.to_cnt = 24'h00_0000;
    end else if (s.to_cnt >= dto_limit(s.dto)) begin
      next_s.dto_err = 1'b1; // (R10)
    end else begin
      next_s.to_cnt = s.to_cnt + 24'h00_0001; // (R9)
    end

    if (s.mode[card_host_pkg::DMA_MODE_BIT] && dma_done_i) begin
      next_s.under = 1'b0; // (R5)
      next_s.over = 1'b0; // (R5)
    end
    if (underrun_i) begin
      next_s.under = 1'b1;
    end
    if (overrun_i) begin
      next_s.over = 1'b1;
    end

    // flow hold trades bandwidth for never losing fifo data
    next_s.halt = fifo_full_i && xfer_active_i &&
                  (s.cmd[card_host_pkg::DIR_BIT] ? s.mode[card_host_pkg::RD_HOLD_BIT] // (R1)
                                                 : s.mode[card_host_pkg::WR_HOLD_BIT]); // (R2)
    next_s.pad = next_s.mode[card_host_pkg::PAD_SEL_BIT] ? card_host_pkg::PAD_HIGH
                                                         : card_host_pkg::PAD_LOW; // (R4)
    case (s.state)
      card_host_pkg::IDLE: begin
        if (cmd_ok) begin
          next_s.cmd = reg_wdata_i; // (R22)
          next_s.done = 1'b0; // (R24)
          next_s.edges = 7'h00;
          if (new_spc == card_host_pkg::SPC_INTRSP) begin
            next_s.int_pend = 1'b0; // (R18)
          end
          if (new_spc == card_host_pkg::SPC_INT) begin
            next_s.int_pend = 1'b1; // (R18)
          end
          if (new_spc == card_host_pkg::SPC_INIT) begin
            next_s.state = card_host_pkg::INIT; // (R16)
          end else if (new_spc == card_host_pkg::SPC_SYNC) begin
            next_s.state = card_host_pkg::SYNC; // (R17)
          end else begin
            next_s.state = card_host_pkg::SEND;
            next_s.start = 1'b1; // (R15)
          end
        end
      end
      card_host_pkg::INIT: begin
        if (card_edge) begin
          next_s.edges = s.edges + 7'h01;
          if (s.edges == card_host_pkg::INIT_CYCLES - 7'h01) begin
            next_s.state = card_host_pkg::IDLE; // (R16)
            next_s.done = 1'b1;
          end
        end
      end
      card_host_pkg::SYNC: begin
        if (block_end_i) begin
          next_s.state = card_host_pkg::SEND; // (R17)
          next_s.start = 1'b1;
        end
      end
      card_host_pkg::SEND: begin
        if (cmd_sent_i) begin
          next_s.edges = 7'h00;
          if (s.cmd[card_host_pkg::RSP_LSB +: 2] == card_host_pkg::RSP_NONE) begin
            next_s.state = card_host_pkg::IDLE;
            next_s.done = 1'b1; // (R24)
          end else begin
            next_s.state = card_host_pkg::RESP; // (R15)
          end
        end
      end
      card_host_pkg::RESP: begin
        if (resp_start_i) begin
          next_s.state = card_host_pkg::IDLE;
          next_s.done = 1'b1; // (R24)
        end else if (card_edge) begin
          next_s.edges = s.edges + 7'h01;
          if (s.edges == lat_max - 7'h01) begin
            next_s.state = card_host_pkg::IDLE; // (R20)
            next_s.done = 1'b1;
            next_s.resp_to = 1'b1;
          end
        end
      end
      default: next_s.state = card_host_pkg::IDLE;
    endcase

    // after the sequencer, so a newly accepted kind masks the length at once
    next_s.len_out = (next_s.cmd[card_host_pkg::KIND_LSB +: 3] ==
                      card_host_pkg::KIND_SDIO_BYTE) ? card_host_pkg::HALF_RESET
                                                     : next_s.block_length; // (R8)
  end

  // ==========================================
  // registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s <= '0;
      s.state <= card_host_pkg::IDLE;
      s.done <= 1'b1;
      s.block_length <= card_host_pkg::HALF_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // outputs
  assign reg_rdata_o = s.rdata;
  assign card_clk_halt_o = s.halt;
  assign dma_en_o = s.mode[card_host_pkg::DMA_MODE_BIT]; // (R5)
  assign dma_byte_mode_o = s.mode[card_host_pkg::DMA_BYTE_BIT]; // (R3)
  assign pad_byte_o = s.pad;
  assign block_length_o = s.len_out;
  assign block_or_byte_count_o = s.count;
  assign card_slot_select_o = s.slot;
  assign card_bus_width_o = s.bus;
  assign cmd_start_o = s.start;
  assign init_seq_o = s.state[1];
  assign command_index_o = s.cmd[card_host_pkg::IDX_LSB +: 6];
  assign command_argument_value_o = s.arg;
  assign response_kind_o = s.cmd[card_host_pkg::RSP_LSB +: 2];
  assign open_drain_select_o = s.cmd[card_host_pkg::OD_BIT]; // (R19)
  assign transfer_control_o = s.cmd[card_host_pkg::TRC_LSB +: 2];
  assign transfer_direction_o = s.cmd[card_host_pkg::DIR_BIT];
  assign transfer_kind_o = s.cmd[card_host_pkg::KIND_LSB +: 3];
  assign sdio_suspend_resume_code_o = s.cmd[card_host_pkg::SDIO_SR_LSB +: 2]; // (R21)
  assign command_done_flag_o = s.done;
  assign data_timeout_error_o = s.dto_err;

  // ==========================================
  // checks
  logic cmd_wr;
  assign cmd_wr = reg_wr_i && reg_addr_i == card_host_pkg::CMD_OFS;

  property p_read_hold;
    @(posedge clock_i) disable iff (rst_i)
    fifo_full_i && xfer_active_i && s.cmd[card_host_pkg::DIR_BIT]
      && s.mode[card_host_pkg::RD_HOLD_BIT] |=> card_clk_halt_o;
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read hold missing"); // (R1)

  property p_write_hold;
    @(posedge clock_i) disable iff (rst_i)
    fifo_full_i && xfer_active_i && !s.cmd[card_host_pkg::DIR_BIT]
      && s.mode[card_host_pkg::WR_HOLD_BIT] |=> card_clk_halt_o;
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write hold missing"); // (R2)

  property p_pad;
    @(posedge clock_i) disable iff (rst_i)
    ##1 pad_byte_o == (s.mode[card_host_pkg::PAD_SEL_BIT] ? 8'hFF : 8'h00);
  endproperty
  a_pad: assert property (p_pad) else $error("pad byte wrong"); // (R4)

  property p_flags_clear;
    @(posedge clock_i) disable iff (rst_i)
    dma_en_o && dma_done_i && !underrun_i && !overrun_i |=> !s.under && !s.over;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags kept"); // (R5)

  property p_sdio_len;
    @(posedge clock_i) disable iff (rst_i)
    transfer_kind_o == card_host_pkg::KIND_SDIO_BYTE |-> block_length_o == 16'h0000;
  endproperty
  a_sdio_len: assert property (p_sdio_len) else $error("length not ignored"); // (R8)

  property p_protect;
    @(posedge clock_i) disable iff (rst_i)
    cmd_wr && !command_done_flag_o |=> $stable(s.cmd);
  endproperty
  a_protect: assert property (p_protect) else $error("busy command changed"); // (R13)

  property p_int_only;
    @(posedge clock_i) disable iff (rst_i)
    cmd_wr && s.int_pend && reg_wdata_i[10:8] != card_host_pkg::SPC_INTRSP |=> $stable(s.cmd);
  endproperty
  a_int_only: assert property (p_int_only) else $error("interrupt lock broken"); // (R14)

  property p_done_clear;
    @(posedge clock_i) disable iff (rst_i)
    cmd_wr && command_done_flag_o && !s.int_pend |=> !command_done_flag_o;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done not cleared"); // (R24)

  property p_timeout;
    @(posedge clock_i) disable iff (rst_i)
    data_wait_i && s.to_cnt >= dto_limit(s.dto) |=> data_timeout_error_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged"); // (R10)

  property p_start_pulse;
    @(posedge clock_i) disable iff (rst_i)
    cmd_start_o |=> !cmd_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long"); // (R15)

  c_init: cover property (@(posedge clock_i) disable iff (rst_i) $fell(init_seq_o));
  c_resp: cover property (@(posedge clock_i) disable iff (rst_i)
    s.state == card_host_pkg::RESP ##1 s.state == card_host_pkg::IDLE);
  c_dto: cover property (@(posedge clock_i) disable iff (rst_i) $rose(data_timeout_error_o));
endmodule

// *** bench/card_model.sv ***
`timescale 1ns/1ns
module card_model (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       cmd_start_i,
  input  wire logic       done_i,
  input  wire logic [7:0] resp_delay_i,
  output logic            card_clk_o,
  output logic            cmd_sent_o,
  output logic            resp_start_o
);
  logic last;
  int   n;
  // ==========================================
  // card clock stands low while no command runs
  initial begin
    card_clk_o = 1'b0;
    #4;
    forever begin
      #62 if (!done_i || card_clk_o) card_clk_o = ~card_clk_o;
      #63 if (!done_i || card_clk_o) card_clk_o = ~card_clk_o;
    end
  end
  // ==========================================
  // shift out, then answer after resp_delay_i card edges; zero means silent
  initial begin
    cmd_sent_o = 1'b0;
    resp_start_o = 1'b0;
    forever begin
      @(posedge clock_i);
      if (cmd_start_i === 1'b1 && !rst_i) begin
        repeat (3) @(posedge clock_i);
        cmd_sent_o <= 1'b1;
        @(posedge clock_i);
        cmd_sent_o <= 1'b0;
        n = 0;
        last = card_clk_o;
        while (n < resp_delay_i && done_i !== 1'b1) begin
          @(posedge clock_i);
          if (card_clk_o && !last) n++;
          last = card_clk_o;
        end
        if (n != 0 && n == resp_delay_i) begin
          resp_start_o <= 1'b1;
          @(posedge clock_i);
          resp_start_o <= 1'b0;
        end
      end
    end
  end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic        clock_i, rst_i, reg_wr_i, reg_rd_i, card_clk, cmd_sent, resp_start;
  logic        fifo_full_i, xfer_active_i, data_wait_i, block_end_i;
  logic        dma_done_i, underrun_i, overrun_i, ck_q;
  logic [7:0]  reg_addr_i, resp_delay, pad;
  logic [31:0] reg_wdata_i, rdata, arg, w;
  logic        halt, dma_en, byte_m, bus, start, init, od, dir, done, dto_err;
  logic [15:0] blen, block_or_byte_count;
  logic [1:0]  slot, rsp, trc, sdio;
  logic [5:0]  idx;
  logic [2:0]  kind;
  int          num_errors = 0;
  int          checks = 0;
  int          starts = 0;
  int          init_edges = 0;
  int          s;
  int          mult [5] = '{1, 16, 128, 256, 1024};
  logic [7:0]  zero_ofs [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [7:0]  slot_val [3] = '{8'h81, 8'h01, 8'h00};

  card_host_interface u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(rdata), .card_clk_i(card_clk), .fifo_full_i(fifo_full_i),
    .xfer_active_i(xfer_active_i), .data_wait_i(data_wait_i),
    .block_end_i(block_end_i), .cmd_sent_i(cmd_sent), .resp_start_i(resp_start),
    .dma_done_i(dma_done_i), .underrun_i(underrun_i), .overrun_i(overrun_i),
    .card_clk_halt_o(halt), .dma_en_o(dma_en), .dma_byte_mode_o(byte_m),
    .pad_byte_o(pad), .block_length_o(blen), .block_or_byte_count_o(block_or_byte_count),
    .card_slot_select_o(slot), .card_bus_width_o(bus), .cmd_start_o(start),
    .init_seq_o(init), .command_index_o(idx), .command_argument_value_o(arg),
    .response_kind_o(rsp), .open_drain_select_o(od), .transfer_control_o(trc),
    .transfer_direction_o(dir), .transfer_kind_o(kind),
    .sdio_suspend_resume_code_o(sdio), .command_done_flag_o(done),
    .data_timeout_error_o(dto_err)
  );

  card_model u_card (
    .clock_i(clock_i), .rst_i(rst_i), .cmd_start_i(start), .done_i(done),
    .resp_delay_i(resp_delay), .card_clk_o(card_clk), .cmd_sent_o(cmd_sent),
    .resp_start_o(resp_start)
  );

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // ==========================================
  // monitors sample the values settled before each edge
  always @(posedge clock_i) begin
    ck_q <= card_clk;
    if (start === 1'b1) starts <= starts + 1;
    if (card_clk && !ck_q && init === 1'b1) init_edges <= init_edges + 1;
  end

  // ==========================================
  // bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic stat(input logic [31:0] exp);
    rdc(card_host_pkg::STATUS_OFS, exp);
  endtask

  // bounded: init alone needs about 930 cycles
  task automatic wait_done();
    int i;
    for (i = 0; i < 3000; i++) begin
      tick(1);
      if (done === 1'b1) break;
    end
    if (i == 3000) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic cmd(input logic [31:0] c);
    wr(card_host_pkg::CMD_OFS, c);
    wait_done();
  endtask

  // ==========================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
    {fifo_full_i, xfer_active_i, data_wait_i, block_end_i} = '0;
    {dma_done_i, underrun_i, overrun_i} = '0;
    resp_delay = 8'h03;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    tick(1);
    foreach (zero_ofs[k]) rdc(zero_ofs[k], 32'h0000_0000);
    stat(32'h0000_0001);
    check(pad, 8'h00);
    wr(card_host_pkg::MODE_OFS, 32'h0200_F800);
    check({dma_en, byte_m, pad}, {1'b1, 1'b1, 8'hFF});
    rdc(card_host_pkg::BLK_OFS, 32'h0200_0000);
    wr(card_host_pkg::BLK_OFS, 32'h0104_0003);
    rdc(card_host_pkg::MODE_OFS, 32'h0104_F800);
    check({blen, block_or_byte_count}, 32'h0104_0003);
    wr(card_host_pkg::MODE_OFS, 32'h0104_0000);
    check({dma_en, byte_m, pad}, 10'h000);
    foreach (slot_val[k]) begin
      wr(card_host_pkg::SLOT_OFS, {24'h0, slot_val[k]});
      check({bus, slot}, {slot_val[k][7], slot_val[k][1:0]});
      rdc(card_host_pkg::SLOT_OFS, {24'h0, slot_val[k]});
    end
    wr(card_host_pkg::ARG_OFS, 32'hA5C3_0F1E);
    rdc(card_host_pkg::ARG_OFS, 32'hA5C3_0F1E);
    s = starts;
    wr(card_host_pkg::CMD_OFS, 32'h010D_086A);
    check({done, start}, 2'h1);
    wr(card_host_pkg::CMD_OFS, 32'h0000_0015);
    wait_done();
    check({od, rsp, idx}, {1'b1, 2'h1, 6'h2A});
    check({sdio, kind, dir, trc}, {2'h1, 3'h1, 1'b1, 2'h1});
    check(arg, 32'hA5C3_0F1E);
    check(starts - s, 1);
    // transfer kinds 0 to 5, controls and sdio codes 0 to 2, with flow hold per direction
    fifo_full_i <= 1'b1;
    xfer_active_i <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      w = {6'h00, 2'(k % 3), 2'h0, 3'(k), k[0], 2'(k % 3), 10'h000, 6'(k + 8)};
      cmd(w);
      check({sdio, kind, dir, trc}, {2'(k % 3), 3'(k), k[0], 2'(k % 3)});
      check(blen, (k == 4) ? 16'h0000 : 16'h0104);
      wr(card_host_pkg::MODE_OFS, 32'h0104_0800);
      tick(2);
      check(halt, k[0]);
      wr(card_host_pkg::MODE_OFS, 32'h0104_1000);
      tick(2);
      check(halt, !k[0]);
    end
    fifo_full_i <= 1'b0;
    tick(2);
    check(halt, 1'b0);
    resp_delay = 8'h08;
    cmd(32'h0000_0041);
    stat(32'h0010_0001);
    cmd(32'h0000_1082);
    check(rsp, 2'h2);
    stat(32'h0000_0001);
    s = starts;
    wr(card_host_pkg::CMD_OFS, 32'h0000_0100);
    check(init, 1'b1);
    wait_done();
    check({init_edges[7:0], 8'(starts - s)}, 16'h4A00);
    wr(card_host_pkg::CMD_OFS, 32'h0000_0211);
    tick(6);
    check(starts - s, 0);
    block_end_i <= 1'b1;
    tick(1);
    block_end_i <= 1'b0;
    wait_done();
    check(starts - s, 1);
    cmd(32'h0000_0428);
    s = starts;
    wr(card_host_pkg::CMD_OFS, 32'h0000_0007);
    tick(2);
    check({idx, 8'(starts - s)}, {6'h28, 8'h00});
    cmd(32'h0000_0527);
    check(idx, 6'h27);
    cmd(32'h0000_0003);
    check(idx, 6'h03);
    check(od, 1'b0);
    for (int m = 0; m < 5; m++) begin
      wr(card_host_pkg::DTO_OFS, {25'h0, 3'(m), 4'h2});
      rdc(card_host_pkg::DTO_OFS, {25'h0, 3'(m), 4'h2});
      data_wait_i <= 1'b1;
      tick(2 * mult[m]);
      data_wait_i <= 1'b0;
      tick(2);
      check(dto_err, 1'b0);
      data_wait_i <= 1'b1;
      tick(2 * mult[m] + 1);
      data_wait_i <= 1'b0;
      tick(2);
      check(dto_err, 1'b1);
      stat(32'h0040_0001);
    end
    wr(card_host_pkg::MODE_OFS, 32'h0104_8000);
    check(dma_en, 1'b1);
    for (int e = 0; e < 2; e++) begin
      {overrun_i, underrun_i} <= 2'h3;
      tick(1);
      {overrun_i, underrun_i} <= 2'h0;
      stat(32'hC000_0001);
      dma_done_i <= 1'b1;
      tick(1);
      dma_done_i <= 1'b0;
      stat(e ? 32'hC000_0001 : 32'h0000_0001);
      wr(card_host_pkg::MODE_OFS, 32'h0104_0000);
    end
    conclude();
  end
endmodule
